// [core/imtc_pkg.sv]
// Purpose: Shared constants and types for the two-wire master controller.
// Assumes: Avalon-MM slave with 32-bit data, byte addresses, 25 MHz clock.
// Notes:   Bus lines are open-drain; enable high pulls the line low.
package imtc_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [3:0] OFS_DATA = 4'h0;
    localparam logic [3:0] OFS_STAT = 4'h4;
    localparam logic [3:0] OFS_CTRL = 4'h8;
    localparam logic [3:0] OFS_BRG = 4'hC;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTL_EN = 7;
    localparam int CTL_START = 6;
    localparam int CTL_STOP = 5;
    localparam int CTL_FLUSH = 4;
    localparam int CTL_NAK = 3;
    localparam int CTL_TXI = 2;
    localparam int ST_TDE = 7;
    localparam int ST_RDF = 6;
    localparam int ST_ACK = 5;
    localparam int ST_NACK_INTERRUPT_FLAG = 4;
    localparam int ST_BUSY = 3;

    // ----------------------------------------------------------------
    // Reset values and counts
    // ----------------------------------------------------------------
    localparam logic [15:0] BRG_RST = 16'h0019;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [1:0] PH_SET = 2'h0;
    localparam logic [1:0] PH_RISE = 2'h1;
    localparam logic [1:0] PH_HIGH = 2'h2;
    localparam logic [1:0] PH_FALL = 2'h3;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE,
        S_START,
        S_BITS,
        S_TXSTALL,
        S_ACK,
        S_TXWAIT,
        S_NACKHOLD,
        S_RXWAIT,
        S_STOP
    } imtc_state_t;

    // One sample of both bus lines
    typedef struct packed {
        logic scl;
        logic sda;
    } imtc_pins_t;

    // Software control bits
    typedef struct packed {
        logic controller_enable;
        logic start;
        logic stop;
        logic nak;
        logic tx_irq_enable;
    } imtc_ctrl_t;

endpackage

// [core/imtc_tick.sv]
// Purpose: Quarter-bit enable pulse for the serial bus timing.
// Assumes: Divisor comes from a software register; zero acts as one.
// Notes:   Counter restarts while run is low so each transfer starts aligned.
module imtc_tick
    import imtc_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic run,
    input wire logic [W-1:0] div,
    output logic tick
);

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic hit;

    // ----------------------------------------------------------------
    // Divider
    // ----------------------------------------------------------------
    assign hit = run && (cnt_reg + W'(1) >= div);
    assign cnt_next = (!run || hit) ? '0 : cnt_reg + W'(1);

    // Count and one-cycle pulse
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick <= hit;
        end
    end

endmodule

// [core/imtc_core.sv]
// Purpose: Master-only two-wire controller with Avalon-MM register access.
// Assumes: Slaves may stretch the clock line; the controller waits for it.
// Notes:   Open-drain pins: *_out is always 0, *_oe high pulls the line low.
module imtc_core
    import imtc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic irq
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    imtc_state_t state_reg, state_next;
    logic [1:0] phase_reg, phase_next;
    logic [2:0] bitcnt_reg, bitcnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] tx_data_reg;
    logic [7:0] rx_data_reg;
    logic [15:0] brg_reg;
    imtc_ctrl_t ctrl_reg;
    logic tde_reg, rdf_reg, ack_reg, nack_interrupt_flag_reg;
    logic is_addr_reg, is_addr_next;
    logic rd_mode_reg, rd_mode_next;
    logic addr_rd_reg, addr_rd_next;
    logic smp_reg, smp_next;
    logic scl_oe_next, sda_oe_next;
    imtc_pins_t sync1_reg, sync2_reg;
    logic tick;

    // FSM side effects toward registers
    logic load_tx;
    logic set_rdf;
    logic set_nack_interrupt_flag;
    logic ack_upd;
    logic clr_start;
    logic clr_stop;

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    // Two stages; only the second is looked at by the logic
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
        end else begin
            sync1_reg <= '{scl: scl_in, sda: sda_in};
            sync2_reg <= sync1_reg;
        end
    end

    // ----------------------------------------------------------------
    // Avalon-MM decode
    // ----------------------------------------------------------------
    // One wait cycle per access: request seen, then accepted
    wire req = avs_read || avs_write;
    wire acc = req && !avs_waitrequest;
    wire wr_acc = acc && avs_write;
    wire rd_acc = acc && avs_read;
    wire wr_data = wr_acc && (avs_address == OFS_DATA);
    wire wr_stat = wr_acc && (avs_address == OFS_STAT);
    wire wr_ctrl = wr_acc && (avs_address == OFS_CTRL);
    wire wr_brg = wr_acc && (avs_address == OFS_BRG);
    wire rd_data = rd_acc && (avs_address == OFS_DATA);
    wire busy = (state_reg != S_IDLE);

    wire [7:0] stat_val = {tde_reg, rdf_reg, ack_reg, nack_interrupt_flag_reg, busy, 3'h0};
    wire [7:0] ctrl_val = {ctrl_reg.controller_enable, ctrl_reg.start,
                           ctrl_reg.stop, 1'b0, ctrl_reg.nak,
                           ctrl_reg.tx_irq_enable, 2'h0};
    wire [31:0] rd_mux =
        (avs_address == OFS_DATA) ? {24'h0, rx_data_reg} :
        (avs_address == OFS_STAT) ? {24'h0, stat_val} :
        (avs_address == OFS_CTRL) ? {24'h0, ctrl_val} :
        (avs_address == OFS_BRG) ? {16'h0, brg_reg} : 32'h0;

    // Handshake; unmapped reads return zero, writes are dropped
    always_ff @(posedge clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            avs_waitrequest <= !(req && avs_waitrequest);
            if (req && avs_waitrequest) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    // Software writes win over the hardware self-clear
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_reg <= '0;
            brg_reg <= BRG_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg.controller_enable <= avs_writedata[CTL_EN];
                ctrl_reg.start <= avs_writedata[CTL_START];
                ctrl_reg.stop <= avs_writedata[CTL_STOP];
                ctrl_reg.nak <= avs_writedata[CTL_NAK];
                ctrl_reg.tx_irq_enable <= avs_writedata[CTL_TXI];
            end else begin
                if (clr_start) begin
                    ctrl_reg.start <= 1'b0;
                end
                if (clr_stop) begin
                    ctrl_reg.stop <= 1'b0;
                end
            end
            if (wr_brg) begin
                brg_reg <= avs_writedata[15:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Data and status flags
    // ----------------------------------------------------------------
    wire flush = wr_ctrl && avs_writedata[CTL_FLUSH]
                 && (avs_writedata[CTL_START] || avs_writedata[CTL_STOP]);

    // A data write wins over a load: the old byte is shifted, new one kept
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_data_reg <= DATA_RST;
            tde_reg <= 1'b1;
        end else if (wr_data) begin
            tx_data_reg <= avs_writedata[7:0];
            tde_reg <= 1'b0;
        end else if (load_tx || flush) begin
            tde_reg <= 1'b1;
        end
    end

    // Receive byte; a hardware set beats a clearing read
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_data_reg <= DATA_RST;
            rdf_reg <= 1'b0;
        end else if (set_rdf) begin
            rx_data_reg <= shift_reg;
            rdf_reg <= 1'b1;
        end else if (rd_data) begin
            rdf_reg <= 1'b0;
        end
    end

    // Nack flag clears by writing 1; set wins. Ack bit follows sample
    always_ff @(posedge clk) begin
        if (srst) begin
            nack_interrupt_flag_reg <= 1'b0;
            ack_reg <= 1'b0;
        end else begin
            if (set_nack_interrupt_flag) begin
                nack_interrupt_flag_reg <= 1'b1;
            end else if (wr_stat && avs_writedata[ST_NACK_INTERRUPT_FLAG]) begin
                nack_interrupt_flag_reg <= 1'b0;
            end
            if (ack_upd) begin
                ack_reg <= !smp_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt request
    // ----------------------------------------------------------------
    wire irq_src = (ctrl_reg.tx_irq_enable && tde_reg)
                   || rdf_reg || nack_interrupt_flag_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= ctrl_reg.controller_enable && irq_src;
        end
    end

    // ----------------------------------------------------------------
    // Bit timing
    // ----------------------------------------------------------------
    // Quarter-bit pulses only while a transfer is in flight
    imtc_tick #(
        .W(16)
    ) u_tick (
        .clk(clk),
        .srst(srst),
        .run(busy),
        .div(brg_reg),
        .tick(tick)
    );

    // High phase waits for the line really high: slaves may stretch
    wire scl_hi = sync2_reg.scl;
    wire step = tick && ((phase_reg != PH_HIGH) || scl_hi);
    wire bit_end = step && (phase_reg == PH_FALL);
    wire may_restart = ctrl_reg.start && !ctrl_reg.stop && !tde_reg;
    wire wr_byte = !rd_mode_reg;

    // ----------------------------------------------------------------
    // Transaction sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        phase_next = step ? phase_reg + 2'h1 : phase_reg;
        bitcnt_next = bitcnt_reg;
        shift_next = shift_reg;
        is_addr_next = is_addr_reg;
        rd_mode_next = rd_mode_reg;
        addr_rd_next = addr_rd_reg;
        smp_next = smp_reg;
        scl_oe_next = scl_oe;
        sda_oe_next = sda_oe;
        load_tx = 1'b0;
        set_rdf = 1'b0;
        set_nack_interrupt_flag = 1'b0;
        ack_upd = 1'b0;
        clr_start = 1'b0;
        clr_stop = 1'b0;
        case (state_reg)
            S_IDLE: begin
                phase_next = PH_SET;
                scl_oe_next = 1'b0;
                sda_oe_next = 1'b0;
                // Needs both the request and a written byte
                if (ctrl_reg.controller_enable && ctrl_reg.start
                    && !tde_reg) begin
                    state_next = S_START;
                end
            end
            S_START: begin
                // Also serves as repeated start from a low clock line
                if (step) begin
                    case (phase_reg)
                        PH_SET: sda_oe_next = 1'b0;
                        PH_RISE: scl_oe_next = 1'b0;
                        PH_HIGH: sda_oe_next = 1'b1;
                        default: begin
                            scl_oe_next = 1'b1;
                            clr_start = 1'b1;
                            load_tx = 1'b1;
                            shift_next = tx_data_reg;
                            is_addr_next = 1'b1;
                            rd_mode_next = 1'b0;
                            addr_rd_next = tx_data_reg[0];
                            bitcnt_next = LAST_BIT;
                            state_next = S_BITS;
                        end
                    endcase
                end
            end
            S_BITS: begin
                if (step) begin
                    case (phase_reg)
                        PH_SET: sda_oe_next = wr_byte && !shift_reg[7];
                        PH_RISE: scl_oe_next = 1'b0;
                        PH_HIGH: shift_next = {shift_reg[6:0], sync2_reg.sda};
                        default: scl_oe_next = 1'b1;
                    endcase
                end
                if (bit_end) begin
                    bitcnt_next = bitcnt_reg - 3'h1;
                    if (bitcnt_reg == 3'h0) begin
                        // Stall only when no more data and no start/stop
                        if (wr_byte && tde_reg && !addr_rd_reg
                            && !ctrl_reg.start && !ctrl_reg.stop) begin
                            state_next = S_TXSTALL;
                        end else begin
                            state_next = S_ACK;
                        end
                    end
                end
            end
            S_TXSTALL: begin
                // Clock held low; ack clock waits for byte n+1
                phase_next = PH_SET;
                if (!tde_reg || ctrl_reg.start || ctrl_reg.stop) begin
                    state_next = S_ACK;
                end
            end
            S_ACK: begin
                // Ninth clock: slave answers on writes, master on reads
                if (step) begin
                    case (phase_reg)
                        PH_SET: sda_oe_next = !wr_byte && !ctrl_reg.nak;
                        PH_RISE: scl_oe_next = 1'b0;
                        PH_HIGH: smp_next = sync2_reg.sda;
                        default: scl_oe_next = 1'b1;
                    endcase
                end
                if (bit_end) begin
                    bitcnt_next = LAST_BIT;
                    if (!wr_byte) begin
                        set_rdf = 1'b1;
                        state_next = S_RXWAIT;
                    end else begin
                        ack_upd = 1'b1;
                        is_addr_next = 1'b0;
                        if (smp_reg && ctrl_reg.stop) begin
                            state_next = S_STOP;
                        end else if (smp_reg) begin
                            set_nack_interrupt_flag = 1'b1;
                            state_next = S_NACKHOLD;
                        end else if (is_addr_reg && addr_rd_reg) begin
                            rd_mode_next = 1'b1;
                            state_next = ctrl_reg.stop ? S_STOP : S_BITS;
                        end else begin
                            state_next = S_TXWAIT;
                        end
                    end
                end
            end
            S_TXWAIT: begin
                phase_next = PH_SET;
                if (may_restart) begin
                    state_next = S_START;
                end else if (!tde_reg) begin
                    load_tx = 1'b1;
                    shift_next = tx_data_reg;
                    state_next = S_BITS;
                end else if (ctrl_reg.stop) begin
                    state_next = S_STOP;
                end
            end
            S_NACKHOLD: begin
                // Bus held with the clock low until software decides
                phase_next = PH_SET;
                if (ctrl_reg.stop) begin
                    state_next = S_STOP;
                end else if (may_restart) begin
                    state_next = S_START;
                end
            end
            S_RXWAIT: begin
                // Next byte fetched only once software has read this one
                phase_next = PH_SET;
                if (!rdf_reg) begin
                    if (ctrl_reg.stop) begin
                        state_next = S_STOP;
                    end else if (may_restart) begin
                        state_next = S_START;
                    end else begin
                        state_next = S_BITS;
                    end
                end
            end
            S_STOP: begin
                if (step) begin
                    case (phase_reg)
                        PH_SET: sda_oe_next = 1'b1;
                        PH_RISE: scl_oe_next = 1'b0;
                        PH_HIGH: sda_oe_next = 1'b1;
                        default: begin
                            sda_oe_next = 1'b0;
                            clr_stop = 1'b1;
                            state_next = S_IDLE;
                        end
                    endcase
                end
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Sequencer state
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= S_IDLE;
            phase_reg <= PH_SET;
            bitcnt_reg <= LAST_BIT;
            shift_reg <= DATA_RST;
        end else begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            bitcnt_reg <= bitcnt_next;
            shift_reg <= shift_next;
        end
    end

    // Transfer attributes and sample
    always_ff @(posedge clk) begin
        if (srst) begin
            is_addr_reg <= 1'b0;
            rd_mode_reg <= 1'b0;
            addr_rd_reg <= 1'b0;
            smp_reg <= 1'b1;
        end else begin
            is_addr_reg <= is_addr_next;
            rd_mode_reg <= rd_mode_next;
            addr_rd_reg <= addr_rd_next;
            smp_reg <= smp_next;
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    // Lines only ever pulled low; the level is fixed at zero
    always_ff @(posedge clk) begin
        if (srst) begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            scl_oe <= scl_oe_next;
            sda_oe <= sda_oe_next;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

endmodule

// [test/imtc_chk.sv]
// Purpose: Port checks for imtc_core.
// Assumes: One clock domain, sync reset.
// Notes:   Sticky flags disarm only on reset.
module imtc_chk
    import imtc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    logic data_reg;
    logic go_reg;
    // Writes accepted by the slave
    wire wr_ok = avs_write && !avs_waitrequest;
    wire wr_dat = wr_ok && avs_address == OFS_DATA;
    wire wr_go = wr_ok && avs_address == OFS_CTRL && avs_writedata[CTL_START];
    // Remembers any arming since reset
    always_ff @(posedge clk) begin
        if (srst) begin
            data_reg <= 1'b0;
            go_reg <= 1'b0;
        end else begin
            data_reg <= data_reg | wr_dat;
            go_reg <= go_reg | wr_go;
        end
    end
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("no answer after one wait");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_unmapped: assert property (avs_read && avs_waitrequest
        && avs_address[1:0] != 2'h0 |=> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!avs_read && !avs_write
        |=> $stable(avs_readdata)) else $error("readdata moved while idle");
    a_lines_od: assert property (!scl_out && !sda_out)
        else $error("line driven high");
    a_no_start: assert property ($rose(sda_oe) && !scl_oe
        |-> data_reg && go_reg) else $error("start not armed");
    a_start_hold: assert property ($rose(sda_oe) && !scl_oe
        |=> !scl_oe && sda_oe) else $error("start not held");
    a_stop_idle: assert property ($fell(sda_oe) && !scl_oe
        |=> !scl_oe && !sda_oe) else $error("stop not followed by idle");
    c_start: cover property ($rose(sda_oe) && !scl_oe);
    c_stop: cover property ($fell(sda_oe) && !scl_oe);
    c_irq: cover property ($rose(irq));
endmodule
bind imtc_core imtc_chk imtc_chk_i (.clk, .srst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .scl_out,
    .scl_oe, .sda_out, .sda_oe, .irq);

// [test/imtc_slave.sv]
// Purpose: Behavioural two-wire slave.
// Assumes: Pull-ups on both lines, 7-bit address.
// Notes:   Stretch on acknowledge when slow is set.
module imtc_slave #(
    parameter logic [6:0] ADDR = 7'h50
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic ack_en,
    input wire logic slow,
    input wire logic [7:0] rd_byte,
    output logic sda_pull,
    output logic scl_pull,
    output logic [7:0] got
);
    timeunit 1ns;
    timeprecision 1ps;
    int bitn = -1;
    logic first, rd, mack;
    logic [7:0] sh;
    initial begin
        sda_pull = 1'b0;
        scl_pull = 1'b0;
    end
    // Start or restart opens a byte, stop idles
    always @(negedge sda) if (scl) begin
        bitn = 0;
        first = 1'b1;
    end
    always @(posedge sda) if (scl) bitn = -1;
    // Sample on rising clock, MSB first
    always @(posedge scl) if (bitn >= 0) begin
        if (bitn < 8) sh = {sh[6:0], sda};
        else mack = !sda;
        bitn++;
    end
    // Drive on falling clock only
    always @(negedge scl) if (bitn >= 0) begin
        sda_pull = 1'b0;
        if (bitn == 8) begin
            got = sh;
            if (first) rd = sh[0];
            sda_pull = ack_en && (first ? sh[7:1] == ADDR : !rd);
            if (first && sh[7:1] != ADDR) bitn = -1;
            if (slow) begin
                scl_pull = 1'b1;
                #600 scl_pull = 1'b0;
            end
        end else if (bitn == 9) begin
            bitn = rd && !mack ? -1 : 0;
            first = 1'b0;
            sda_pull = rd && mack && !rd_byte[7];
        end else sda_pull = rd && !first && !rd_byte[7 - bitn];
    end
endmodule

// [test/tb.sv]
// Purpose: Register-level bench for the two-wire master.
// Assumes: One slave at 0x50.
// Notes:   Divisor 2 gives a 400 ns bit; the high phase waits out the synchroniser.
module tb
    import imtc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic ack_en = 1'b1;
    logic slow = 1'b0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, scl_oe, sda_oe, irq, s_sda, s_scl;
    logic [7:0] got;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    int n_start = 0, n_stop = 0;
    int ns0, np0;
    // Open-drain lines with pull-ups
    wire scl_w = !(scl_oe || s_scl);
    wire sda_w = !(sda_oe || s_sda);
    imtc_core imtc_core_i (.clk, .srst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .scl_in(scl_w),
        .scl_out(), .scl_oe, .sda_in(sda_w), .sda_out(), .sda_oe, .irq);
    imtc_slave imtc_slave_i (.scl(scl_w), .sda(sda_w), .ack_en, .slow,
        .rd_byte(8'h96), .sda_pull(s_sda), .scl_pull(s_scl), .got);
    always #20 clk = ~clk;
    // Condition counters, hang guard
    always @(negedge sda_w) if (scl_w) n_start++;
    always @(posedge sda_w) if (scl_w) n_stop++;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            finish_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Request held until waitrequest is low
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        v = avs_readdata;
        avs_read <= 1'b0;
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] e, string nm);
        logic [31:0] v;
        rd(a, v);
        chk(nm, v, e);
    endtask
    task automatic wait_stop();
        logic [31:0] v;
        v = 32'h20;
        while (v[CTL_STOP] !== 1'b0) rd(OFS_CTRL, v);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        rc(OFS_STAT, 32'h80, "stat_rst");
        rc(OFS_BRG, 32'h19, "brg_rst");
        rc(4'h2, 32'h0, "unmapped");
        wr(OFS_BRG, 32'h2);
        wr(OFS_CTRL, 32'h84);
        repeat (3) @(posedge clk);
        chk("irq_tx", irq, 1'b1);
        wr(OFS_CTRL, 32'h80);
        repeat (3) @(posedge clk);
        chk("irq_off", irq, 1'b0);
        // Write: stall before ack
        wr(OFS_CTRL, 32'hC0);
        repeat (40) @(posedge clk);
        chk("no_start", sda_oe, 1'b0);
        wr(OFS_DATA, 32'hA0);
        repeat (150) @(posedge clk);
        chk("tx_stall", scl_oe, 1'b1);
        chk("msb_first", got, 8'hA0);
        wr(OFS_DATA, 32'h3C);
        repeat (30) @(posedge clk);
        wr(OFS_CTRL, 32'hA0);
        wait_stop();
        chk("data_byte", got, 8'h3C);
        rc(OFS_STAT, 32'hA0, "ack_set");
        // Nack, then flush with stop
        ack_en <= 1'b0;
        wr(OFS_DATA, 32'hA0);
        wr(OFS_CTRL, 32'hC0);
        repeat (150) @(posedge clk);
        wr(OFS_DATA, 32'h55);
        repeat (20) @(posedge clk);
        rc(OFS_STAT, 32'h18, "nack_flag");
        chk("nack_hold", scl_oe, 1'b1);
        chk("irq_nack", irq, 1'b1);
        wr(OFS_CTRL, 32'hB0);
        wait_stop();
        rc(OFS_STAT, 32'h90, "flushed");
        wr(OFS_STAT, 32'h10);
        rc(OFS_STAT, 32'h80, "nack_clr");
        // Probe repeated until acknowledged
        for (int i = 0; i < 2; i++) begin
            ack_en <= i[0];
            slow <= i[0];
            wr(OFS_DATA, 32'hA0);
            wr(OFS_CTRL, 32'hE0);
            wait_stop();
            rc(OFS_STAT, i ? 32'hA0 : 32'h80, "probe");
        end
        // Restart into a read of two bytes
        ns0 = n_start;
        np0 = n_stop;
        wr(OFS_DATA, 32'hA0);
        wr(OFS_CTRL, 32'hC0);
        repeat (150) @(posedge clk);
        wr(OFS_CTRL, 32'hC0);
        wr(OFS_DATA, 32'hA1);
        repeat (250) @(posedge clk);
        chk("rx_stall", scl_oe, 1'b1);
        chk("irq_rx", irq, 1'b1);
        wr(OFS_CTRL, 32'h88);
        rc(OFS_DATA, 32'h96, "rx_byte1");
        repeat (150) @(posedge clk);
        rc(OFS_STAT, 32'hE8, "rx_full");
        wr(OFS_CTRL, 32'hA8);
        rc(OFS_DATA, 32'h96, "rx_byte2");
        wait_stop();
        chk("starts", n_start - ns0, 32'h2);
        chk("stops", n_stop - np0, 32'h1);
        finish_test();
    end
endmodule
